// ### owl_dev_model.sv
// Behavioural model of the debug-port device on the far side of the wire.
`timescale 1ns/1ns
module owl_dev_model
    import owl_pkg::*;
(
    input wire logic core_clk,
    input wire logic wire_lvl,
    input wire logic send_go,
    input wire logic [7:0] send_byte,
    input wire logic send_bad,
    input wire logic ack_en,
    input wire logic [7:0] ack_byte,
    output logic dev_oe,
    output logic [7:0] rx_byte,
    output logic rx_bad,
    output int rx_cnt,
    output int brk_cnt
);
    logic prev = 1'b1;
    logic en = 1'b0;
    // Parity check stays on, so a wrong parity bit from the controller is caught.
    logic par_off = 1'b0;
    frame_t f;
    // Sends one frame; apart from the 50-cycle enable answer, the pin is only pulled while a frame goes out.
    task automatic put(input frame_t v);
        for (int i = 0; i < FRAME_BITS; i++) begin
            dev_oe <= ~v[i];
            repeat (BIT_CYC) @(posedge core_clk);
        end
        dev_oe <= 1'b0;
    endtask
    initial begin
        dev_oe = 1'b0;
        rx_cnt = 0;
        brk_cnt = 0;
    end
    // Polls the wire once a cycle, so it never listens while it talks.
    always @(posedge core_clk) begin
        if (send_go) begin
            put({2'b11, ^send_byte ^ send_bad, send_byte, 1'b0});
        end else if (prev && !wire_lvl && !en) begin
            dev_oe <= 1'b1;
            repeat (50) @(posedge core_clk);
            dev_oe <= 1'b0;
            en = 1'b1;
            @(posedge core_clk);
        end else if (prev && !wire_lvl) begin
            repeat (BIT_CYC / 2 - 1) @(posedge core_clk);
            for (int i = 0; i < FRAME_BITS; i++) begin
                f[i] = wire_lvl;
                if (i < 11) repeat (BIT_CYC) @(posedge core_clk);
            end
            if (f === FRAME_LOW) begin
                brk_cnt++;
                wait (wire_lvl);
            end else begin
                rx_byte = f[8:1];
                rx_bad = f[0] | ((^f[9:1]) & ~par_off) | ~f[10] | ~f[11];
                rx_cnt++;
                if (ack_en && !rx_bad) begin
                    repeat (2 * BIT_CYC) @(posedge core_clk);
                    put({2'b11, ^ack_byte, ack_byte, 1'b0});
                end
            end
        end
        prev = wire_lvl;
    end
endmodule

// ### owl_host.sv
// Debugger-side controller for the one-wire half-duplex debug link.
`timescale 1ns/1ns
// Summary of operation
// - Frame: start, eight data, even parity, two stops.
// - Idle frame is twelve high bit periods.
// - Sync 0x55 precedes each instruction; a break goes out without it.
// - Wait for ACK after store before continuing.
// - Debugger always initiates; device only answers.
// - Debugger baud must suit selected link clock.
// - Double break with stop bits between resets.
// - Break length follows slowest rate per clock.
// - Enable pulse low 200 ns to 1 us.
// - Send sync within 13.5 ms after enable.
module owl_host
    import owl_pkg::*;
#(
    parameter int BREAK_CYC_16M = BRK16_CYC,
    parameter int BREAK_CYC_8M = BRK8_CYC,
    parameter int BREAK_CYC_4M = BRK4_CYC,
    parameter int SYNC_WIN_CYC = SYNC_WINDOW_CYC,
    parameter logic [7:0] ACK_CHAR = 8'h40
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic cmd_valid,
    input wire cmd_t cmd,
    output logic cmd_ready,
    output logic rsp_valid,
    output rsp_t rsp,
    input wire logic line_in,
    output logic line_out,
    output logic line_oe
);
    typedef enum logic [2:0] {
        S_IDLE, S_EN_PULSE, S_EN_SETTLE, S_EN_WAIT, S_TX, S_RX
    } state_t;
    typedef enum logic [2:0] {NX_DONE, NX_DATA, NX_ACK, NX_GAP, NX_BREAK2} step_t;

    state_t state_ff;
    step_t step_ff;
    cmd_t cmd_ff;
    logic [TMR_W-1:0] tmr_ff;
    logic [1:0] clk_sel_ff;
    logic en_drive_ff;
    logic tx_start_ff;
    frame_t tx_vec_ff;
    logic [TMR_W-1:0] tx_len_ff;
    logic rx_en_ff;
    logic [TMR_W-1:0] brk_len;
    logic tx_done;
    logic drive_low;
    logic rx_done;
    logic [7:0] rx_byte;
    logic rx_err;
    logic idle_w;

    // Break bit time from the clock selection the device is known to use.
    always_comb begin
        case (clk_sel_ff)
            CLKSEL_16M: brk_len = TMR_W'(BREAK_CYC_16M / FRAME_BITS);
            CLKSEL_8M: brk_len = TMR_W'(BREAK_CYC_8M / FRAME_BITS);
            default: brk_len = TMR_W'(BREAK_CYC_4M / FRAME_BITS);
        endcase
    end

    assign idle_w = (state_ff == S_IDLE);

    // Command sequencer; every transfer starts here, the device only answers.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_ff <= S_IDLE;
            step_ff <= NX_DONE;
            cmd_ff <= '0;
            tmr_ff <= '0;
            clk_sel_ff <= CLKSEL_DEFAULT;
            en_drive_ff <= 1'b0;
            tx_start_ff <= 1'b0;
            tx_vec_ff <= FRAME_HIGH;
            tx_len_ff <= BIT_LEN;
            rx_en_ff <= 1'b0;
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp <= '0;
        end else if (ce) begin
            tx_start_ff <= 1'b0;
            rsp_valid <= 1'b0;
            case (state_ff)
                S_IDLE: begin
                    cmd_ready <= 1'b1;
                    if (cmd_valid && cmd_ready) begin
                        cmd_ready <= 1'b0;
                        cmd_ff <= cmd;
                        rsp <= '0;
                        step_ff <= NX_DONE;
                        tx_len_ff <= BIT_LEN;
                        case (cmd.kind)
                            CMD_ENABLE: begin
                                state_ff <= S_EN_PULSE;
                                en_drive_ff <= 1'b1;
                                tmr_ff <= TMR_W'(EN_PULSE_CYC - 1);
                                clk_sel_ff <= CLKSEL_DEFAULT;
                            end
                            CMD_INSTR: begin
                                state_ff <= S_TX;
                                tx_start_ff <= 1'b1;
                                tx_vec_ff <= make_frame(SYNC_CHAR);
                                step_ff <= NX_DATA;
                            end
                            CMD_DATA: begin
                                state_ff <= S_TX;
                                tx_start_ff <= 1'b1;
                                tx_vec_ff <= make_frame(cmd.data);
                                step_ff <= cmd.wait_ack ? NX_ACK : NX_DONE;
                            end
                            CMD_RECV: begin
                                state_ff <= S_RX;
                                rx_en_ff <= 1'b1;
                                tmr_ff <= TMR_W'(RX_TIMEOUT_CYC - 1);
                            end
                            CMD_BREAK, CMD_DBL_BREAK: begin
                                state_ff <= S_TX;
                                tx_start_ff <= 1'b1;
                                tx_vec_ff <= FRAME_LOW;
                                tx_len_ff <= brk_len;
                                clk_sel_ff <= CLKSEL_DEFAULT;
                                step_ff <= (cmd.kind == CMD_DBL_BREAK) ? NX_GAP : NX_DONE;
                            end
                            CMD_IDLE: begin
                                state_ff <= S_TX;
                                tx_start_ff <= 1'b1;
                                tx_vec_ff <= FRAME_HIGH;
                            end
                            CMD_SET_CLK: begin
                                // Mirrors a select value the user wrote to the device.
                                clk_sel_ff <= cmd.data[1:0];
                                rsp_valid <= 1'b1;
                            end
                            default: begin
                                rsp_valid <= 1'b1;
                            end
                        endcase
                    end
                end
                S_EN_PULSE: begin
                    if (tmr_ff == '0) begin
                        en_drive_ff <= 1'b0;
                        state_ff <= S_EN_SETTLE;
                        tmr_ff <= TMR_W'(EN_SETTLE_CYC - 1);
                    end else begin
                        tmr_ff <= tmr_ff - 1'b1;
                    end
                end
                S_EN_SETTLE: begin
                    // Give the device time to grab the wire before looking for high.
                    if (tmr_ff == '0) begin
                        state_ff <= S_EN_WAIT;
                        tmr_ff <= TMR_W'(SYNC_WIN_CYC - 1);
                    end else begin
                        tmr_ff <= tmr_ff - 1'b1;
                    end
                end
                S_EN_WAIT: begin
                    if (line_in) begin
                        state_ff <= S_TX;
                        tx_start_ff <= 1'b1;
                        tx_vec_ff <= make_frame(SYNC_CHAR);
                    end else if (tmr_ff == '0) begin
                        state_ff <= S_IDLE;
                        rsp.timeout <= 1'b1;
                        rsp_valid <= 1'b1;
                    end else begin
                        tmr_ff <= tmr_ff - 1'b1;
                    end
                end
                S_TX: begin
                    if (tx_done) begin
                        tx_len_ff <= BIT_LEN;
                        case (step_ff)
                            NX_DATA: begin
                                tx_start_ff <= 1'b1;
                                tx_vec_ff <= make_frame(cmd_ff.data);
                                step_ff <= NX_DONE;
                            end
                            NX_ACK: begin
                                state_ff <= S_RX;
                                rx_en_ff <= 1'b1;
                                tmr_ff <= TMR_W'(RX_TIMEOUT_CYC - 1);
                            end
                            NX_GAP: begin
                                // Full idle frame between breaks gives the stop bits.
                                tx_start_ff <= 1'b1;
                                tx_vec_ff <= FRAME_HIGH;
                                step_ff <= NX_BREAK2;
                            end
                            NX_BREAK2: begin
                                tx_start_ff <= 1'b1;
                                tx_vec_ff <= FRAME_LOW;
                                tx_len_ff <= brk_len;
                                step_ff <= NX_DONE;
                            end
                            default: begin
                                state_ff <= S_IDLE;
                                rsp_valid <= 1'b1;
                            end
                        endcase
                    end
                end
                S_RX: begin
                    if (rx_done) begin
                        rx_en_ff <= 1'b0;
                        state_ff <= S_IDLE;
                        rsp.data <= rx_byte;
                        rsp.frame_err <= rx_err;
                        rsp.nack <= cmd_ff.wait_ack && (rx_byte != ACK_CHAR);
                        rsp_valid <= 1'b1;
                    end else if (tmr_ff == '0) begin
                        rx_en_ff <= 1'b0;
                        state_ff <= S_IDLE;
                        rsp.timeout <= 1'b1;
                        rsp_valid <= 1'b1;
                    end else begin
                        tmr_ff <= tmr_ff - 1'b1;
                    end
                end
                default: begin
                    state_ff <= S_IDLE;
                end
            endcase
        end
    end

    // Open-drain pin: only low is ever driven, a one simply releases.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            line_oe <= 1'b0;
            line_out <= 1'b0;
        end else if (ce) begin
            line_oe <= en_drive_ff | drive_low;
            line_out <= 1'b0;
        end
    end

    // Bit timing is an exact count of core cycles, so rate error is nil.
    owl_serdes i_owl_serdes (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ce(ce),
        .tx_start(tx_start_ff),
        .tx_vec(tx_vec_ff),
        .tx_len(tx_len_ff),
        .tx_done(tx_done),
        .drive_low(drive_low),
        .rx_en(rx_en_ff),
        .line_in(line_in),
        .rx_done(rx_done),
        .rx_byte(rx_byte),
        .rx_err(rx_err)
    );

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_en_pulse_width: assert property (
        $rose(line_oe) && state_ff == S_EN_PULSE |-> line_oe[*5] ##1 !line_oe)
        else $error("enable pulse length wrong");
    a_instr_sync: assert property (
        tx_start_ff && cmd_ff.kind == CMD_INSTR && step_ff == NX_DATA
        |-> tx_vec_ff == make_frame(SYNC_CHAR))
        else $error("instruction not led by sync");
    a_frame_format: assert property (
        tx_start_ff && tx_len_ff == BIT_LEN && tx_vec_ff != FRAME_HIGH
        |-> !tx_vec_ff[0] && tx_vec_ff[11:10] == 2'b11 && !(^tx_vec_ff[9:1]))
        else $error("data frame badly formed");
    a_idle_release: assert property (
        idle_w && $past(idle_w) && $past(idle_w, 2) |-> !line_oe)
        else $error("wire driven while idle");
    a_break_clksel: assert property (
        tx_start_ff && tx_vec_ff == FRAME_LOW |=> clk_sel_ff == CLKSEL_DEFAULT)
        else $error("break kept old clock select");
    a_dbl_gap: assert property (
        tx_done && state_ff == S_TX && step_ff == NX_GAP
        |=> tx_start_ff && tx_vec_ff == FRAME_HIGH ##1 !line_oe)
        else $error("no stop bits between breaks");
    a_ack_wait: assert property (
        tx_done && state_ff == S_TX && step_ff == NX_ACK
        |=> state_ff == S_RX && rx_en_ff && !tx_start_ff)
        else $error("no ack wait after store");
    a_sync_window: assert property (
        state_ff == S_EN_WAIT && line_in |=> tx_start_ff ##2 line_oe)
        else $error("sync not sent after enable");
    a_break_low: assert property (
        tx_start_ff && tx_vec_ff == FRAME_LOW ##2 line_oe |=> line_oe[*8])
        else $error("break released early");

    c_enable: cover property (state_ff == S_EN_WAIT && line_in);
    c_ack_seen: cover property (state_ff == S_RX && rx_done && !rsp.nack);
    c_dbl_break: cover property (tx_start_ff && step_ff == NX_BREAK2);
endmodule

// ### owl_pkg.sv
// Shared constants, types and frame helper for the one-wire debug link controller.
package owl_pkg;
    // Core clock and the bit timing the controller uses on the wire.
    localparam int CLK_PERIOD_NS = 100;
    localparam int FRAME_BITS = 12;
    localparam int BIT_CYC = 160;
    localparam int SUBS_PER_BIT = 16;
    localparam int SUB_CYC = BIT_CYC / SUBS_PER_BIT;
    localparam int TMR_W = 18;
    localparam int SUB_W = 8;
    localparam logic [TMR_W-1:0] BIT_LEN = TMR_W'(BIT_CYC);
    localparam logic [SUB_W-1:0] SUB_LEN = SUB_W'(SUB_CYC);
    localparam logic [3:0] SUB_LAST = 4'hF;
    localparam logic [3:0] VOTE_FIRST = 4'h7;
    localparam logic [3:0] VOTE_LAST = 4'h9;
    localparam logic [3:0] FRAME_LAST = 4'hB;
    // Enable pulse: at least 200 ns, at most 1 us; 500 ns sits well inside that range.
    localparam int EN_PULSE_NS = 500;
    localparam int EN_PULSE_CYC = (EN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EN_SETTLE_NS = 1000;
    localparam int EN_SETTLE_CYC = (EN_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Sync window after enable, and break lengths per link clock choice.
    localparam int SYNC_WINDOW_US = 13500;
    localparam int SYNC_WINDOW_CYC = SYNC_WINDOW_US * 1000 / CLK_PERIOD_NS;
    localparam int BRK16_US = 6150;
    localparam int BRK8_US = 12300;
    localparam int BRK4_US = 24600;
    localparam int BRK16_CYC = (BRK16_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BRK8_CYC = (BRK8_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BRK4_CYC = (BRK4_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RX_TIMEOUT_BITS = 24;
    localparam int RX_TIMEOUT_CYC = RX_TIMEOUT_BITS * BIT_CYC;
    // Characters and link clock select codes.
    localparam logic [7:0] SYNC_CHAR = 8'h55;
    localparam logic [1:0] CLKSEL_16M = 2'h1;
    localparam logic [1:0] CLKSEL_8M = 2'h2;
    localparam logic [1:0] CLKSEL_4M = 2'h3;
    localparam logic [1:0] CLKSEL_DEFAULT = CLKSEL_4M;
    typedef logic [FRAME_BITS-1:0] frame_t;
    localparam frame_t FRAME_HIGH = 12'hFFF;
    localparam frame_t FRAME_LOW = 12'h000;
    typedef enum logic [2:0] {
        CMD_ENABLE, CMD_INSTR, CMD_DATA, CMD_RECV,
        CMD_BREAK, CMD_DBL_BREAK, CMD_IDLE, CMD_SET_CLK
    } cmd_kind_t;
    typedef struct packed {
        cmd_kind_t kind;
        logic [7:0] data;
        logic wait_ack;
    } cmd_t;
    typedef struct packed {
        logic [7:0] data;
        logic frame_err;
        logic timeout;
        logic nack;
    } rsp_t;
    // Frame sent LSB first: start low, data, even parity, two stop bits.
    function automatic frame_t make_frame(input logic [7:0] d);
        return {2'b11, ^d, d, 1'b0};
    endfunction
endpackage

// ### owl_serdes.sv
// Bit engine: shifts frames onto the wire and votes received bits back in.
`timescale 1ns/1ns
module owl_serdes
    import owl_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic tx_start,
    input wire frame_t tx_vec,
    input wire logic [TMR_W-1:0] tx_len,
    output logic tx_done,
    output logic drive_low,
    input wire logic rx_en,
    input wire logic line_in,
    output logic rx_done,
    output logic [7:0] rx_byte,
    output logic rx_err
);
    logic tx_busy_ff;
    logic [TMR_W-1:0] tx_cnt_ff;
    logic [3:0] tx_idx_ff;
    frame_t tx_sh_ff;
    logic rx_act_ff;
    logic [SUB_W-1:0] sub_cnt_ff;
    logic [3:0] sub_idx_ff;
    logic [3:0] bit_idx_ff;
    logic [1:0] votes_ff;
    frame_t rx_sh_ff;
    logic bit_val;
    frame_t nxt_rx_sh;

    // Transmit shifter; a zero bit pulls the wire low, a one releases it.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tx_busy_ff <= 1'b0;
            tx_cnt_ff <= '0;
            tx_idx_ff <= '0;
            tx_sh_ff <= FRAME_HIGH;
            drive_low <= 1'b0;
            tx_done <= 1'b0;
        end else if (ce) begin
            tx_done <= 1'b0;
            if (tx_start && !tx_busy_ff) begin
                tx_busy_ff <= 1'b1;
                tx_sh_ff <= tx_vec;
                tx_idx_ff <= '0;
                tx_cnt_ff <= tx_len - 1'b1;
                drive_low <= ~tx_vec[0];
            end else if (tx_busy_ff) begin
                if (tx_cnt_ff != '0) begin
                    tx_cnt_ff <= tx_cnt_ff - 1'b1;
                end else if (tx_idx_ff == FRAME_LAST) begin
                    tx_busy_ff <= 1'b0;
                    tx_done <= 1'b1;
                    drive_low <= 1'b0;
                end else begin
                    tx_idx_ff <= tx_idx_ff + 1'b1;
                    tx_sh_ff <= tx_sh_ff >> 1;
                    drive_low <= ~tx_sh_ff[1];
                    tx_cnt_ff <= tx_len - 1'b1;
                end
            end
        end
    end

    // Majority of three middle samples decides each received bit.
    // By the last tick of a bit all three votes are in, so two or more ones mean high.
    assign bit_val = votes_ff[1];
    assign nxt_rx_sh = {bit_val, rx_sh_ff[FRAME_BITS-1:1]};

    // Receiver; armed only while the controller expects an answer.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rx_act_ff <= 1'b0;
            sub_cnt_ff <= '0;
            sub_idx_ff <= '0;
            bit_idx_ff <= '0;
            votes_ff <= '0;
            rx_sh_ff <= FRAME_HIGH;
            rx_done <= 1'b0;
            rx_byte <= '0;
            rx_err <= 1'b0;
        end else if (ce) begin
            rx_done <= 1'b0;
            if (!rx_en) begin
                rx_act_ff <= 1'b0;
            end else if (!rx_act_ff) begin
                if (!line_in) begin
                    rx_act_ff <= 1'b1;
                    sub_cnt_ff <= SUB_LEN - 1'b1;
                    sub_idx_ff <= '0;
                    bit_idx_ff <= '0;
                    votes_ff <= '0;
                end
            end else if (sub_cnt_ff != '0) begin
                sub_cnt_ff <= sub_cnt_ff - 1'b1;
            end else begin
                sub_cnt_ff <= SUB_LEN - 1'b1;
                sub_idx_ff <= sub_idx_ff + 1'b1;
                if (sub_idx_ff >= VOTE_FIRST && sub_idx_ff <= VOTE_LAST) begin
                    votes_ff <= votes_ff + {1'b0, line_in};
                end
                if (sub_idx_ff == SUB_LAST) begin
                    votes_ff <= '0;
                    rx_sh_ff <= nxt_rx_sh;
                    bit_idx_ff <= bit_idx_ff + 1'b1;
                    if (bit_idx_ff == FRAME_LAST) begin
                        rx_act_ff <= 1'b0;
                        rx_done <= 1'b1;
                        rx_byte <= nxt_rx_sh[8:1];
                        rx_err <= nxt_rx_sh[0] | (^nxt_rx_sh[9:1]) | ~nxt_rx_sh[10]
                            | ~nxt_rx_sh[11];
                    end
                end
            end
        end
    end
endmodule

// ### tb_owl_host.sv
// Self-checking bench for the one-wire debug link controller.
`timescale 1ns/1ns
module tb_owl_host;
    import owl_pkg::*;
    localparam logic [7:0] ACK_V = 8'h40;
    logic core_clk = 0, rst_n = 0, ce = 1, cmd_valid = 0, send_go = 0, send_bad = 0, ack_en = 0;
    logic cmd_ready, rsp_valid, line_out, line_oe, wire_lvl, dev_oe, rx_bad;
    cmd_t cmd = '0;
    rsp_t rsp, got;
    logic [7:0] send_byte = 0, ack_byte = 0, rx_byte;
    logic [31:0] seed = 32'hC5D9;
    int rx_cnt, brk_cnt, n0, err_count = 0, compares = 0, cyc = 0, run = 0, last_run = 0;
    int min_run = 999;
    always #50 core_clk = ~core_clk;
    // The pin has a pull-up, so it is low whenever either side pulls.
    assign wire_lvl = ~(line_oe | dev_oe);
    owl_host #(.BREAK_CYC_16M(1200), .BREAK_CYC_8M(2400), .BREAK_CYC_4M(4800),
        .SYNC_WIN_CYC(2000), .ACK_CHAR(ACK_V)) i_owl_host (.core_clk(core_clk),
        .rst_n(rst_n), .ce(ce), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp(rsp), .line_in(wire_lvl), .line_out(line_out),
        .line_oe(line_oe));
    owl_dev_model i_owl_dev_model (.core_clk(core_clk), .wire_lvl(wire_lvl),
        .send_go(send_go), .send_byte(send_byte), .send_bad(send_bad), .ack_en(ack_en),
        .ack_byte(ack_byte), .dev_oe(dev_oe), .rx_byte(rx_byte), .rx_bad(rx_bad),
        .rx_cnt(rx_cnt), .brk_cnt(brk_cnt));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("Error t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic give_verdict();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic issue(input cmd_kind_t k, input logic [7:0] d, input logic wa);
        int n = 0;
        while (cmd_ready !== 1'b1 && n < 50000) begin
            @(posedge core_clk);
            n++;
        end
        cmd_valid <= 1'b1;
        cmd <= '{k, d, wa};
        @(posedge core_clk);
        cmd_valid <= 1'b0;
    endtask
    task automatic wait_rsp();
        int n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (rsp_valid !== 1'b1 && n < 50000);
        chk(rsp_valid, 1);
        got = rsp;
        repeat (3) @(posedge core_clk);
    endtask
    // Length of each controller pull on the wire (line_oe only); a hang ends the run as a failure.
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (line_oe === 1'b1) run <= run + 1;
        else if (run > 0) begin
            last_run <= run;
            if (run < min_run) min_run <= run;
            run <= 0;
        end
        if (cyc == 90000) begin
            err_count++;
            give_verdict();
        end
    end
    // Enable, random stores, reads, idle and every break flavour.
    initial begin
        repeat (20) @(posedge core_clk);
        chk(line_oe, 0);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        // A frozen controller must neither take a command nor touch the wire.
        ce <= 1'b0;
        cmd_valid <= 1'b1;
        cmd <= '{CMD_ENABLE, 8'h00, 1'b0};
        repeat (4) @(posedge core_clk);
        chk({cmd_ready, rsp_valid, line_oe}, 3'b100);
        cmd_valid <= 1'b0;
        ce <= 1'b1;
        @(posedge core_clk);
        issue(CMD_ENABLE, 0, 0);
        wait_rsp();
        chk(got.timeout, 0);
        chk(min_run >= 2 && min_run <= 10, 1);
        chk(rx_byte, SYNC_CHAR);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            ack_en <= 1'b1;
            ack_byte <= (i == 3) ? ~ACK_V : ACK_V;
            issue(CMD_DATA, seed[7:0], 1);
            wait_rsp();
            chk({rx_bad, rx_byte}, {1'b0, seed[7:0]});
            chk(got.nack, i == 3);
        end
        ack_en <= 1'b0;
        n0 = rx_cnt;
        issue(CMD_INSTR, 8'hA5, 0);
        wait_rsp();
        chk(rx_cnt - n0, 2);
        chk(rx_byte, 8'hA5);
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            send_byte <= (i == 2) ? 8'hFF : seed[7:0];
            send_bad <= (i == 1);
            issue(CMD_RECV, 0, 0);
            send_go <= 1'b1;
            @(posedge core_clk);
            send_go <= 1'b0;
            wait_rsp();
            chk({got.frame_err, got.data}, {i == 1, send_byte});
        end
        // A silent far side must end in a timeout answer, not a hang.
        issue(CMD_RECV, 0, 0);
        wait_rsp();
        chk({got.timeout, got.frame_err}, 2'b10);
        n0 = rx_cnt;
        issue(CMD_IDLE, 0, 0);
        wait_rsp();
        chk(rx_cnt - n0, 0);
        for (int c = 1; c < 4; c++) begin
            issue(CMD_SET_CLK, 8'(c), 0);
            wait_rsp();
            issue(CMD_BREAK, 0, 0);
            wait_rsp();
            chk(last_run, 1200 << (c - 1));
        end
        issue(CMD_SET_CLK, CLKSEL_16M, 0);
        wait_rsp();
        issue(CMD_BREAK, 0, 0);
        wait_rsp();
        // The short break is shorter than a frame at the far side; let that frame run out.
        repeat (FRAME_BITS * BIT_CYC) @(posedge core_clk);
        n0 = brk_cnt;
        issue(CMD_BREAK, 0, 0);
        wait_rsp();
        chk(last_run, 4800);
        issue(CMD_DBL_BREAK, 0, 0);
        wait_rsp();
        chk(brk_cnt - n0, 3);
        chk(line_out, 0);
        give_verdict();
    end
endmodule
